// ==== design/lse_executor.sv ====
/*
  Scan executor for relay-logic, timer, counter, skip and jump
  instructions, with program memory and tables behind AXI4-Lite.
  Assumes inputs synchronous to aclk and a master holding one
  write and one read outstanding at most.
*/
`timescale 1ns/10ps
`default_nettype none

module lse_executor #(
  parameter int          PROG_AW     = 8,
  parameter int          TICK_CNT    = lse_pkg::TICK_CYCLES,
  parameter logic [31:0] RETAIN_MASK = 32'h0000_0000
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire lse_pkg::lse_axi_req_t axi_req,
  output var  lse_pkg::lse_axi_rsp_t axi_rsp,
  output var  logic [31:0]           coil_out,
  output var  logic                  scan_active
);
  import lse_pkg::*;

  localparam int TW  = $clog2(TICK_CNT + 1);
  localparam int DSW = $clog2(DELAY_UNIT_CYCLES + 1);

  typedef struct packed {
    lse_state_t         st;
    logic [PROG_AW-1:0] pc;
    logic               line;
    logic               hold;
    logic               skipping;
    logic               skip_clear;
    logic [9:0]         skip_addr;
    logic               jumping;
    logic [9:0]         jump_addr;
    logic [31:0]        inputs;
    logic [31:0]        outs;
    logic [63:0]        snap;
    logic [63:0]        prev;
    logic [15:0][15:0]  regs;
    logic [15:0]        cnt_prev;
    logic [2:0]         tick_pend;
    logic [2:0]         scan_tick;
    logic [TW-1:0]      tick_cnt;
    logic [3:0]         div1;
    logic [3:0]         div2;
    logic [15:0]        dly_cnt;
    logic [DSW-1:0]     dly_sub;
    logic [15:0]        scan_count;
    logic               run;
    logic [PROG_AW-1:0] prog_addr;
    logic [PROG_AW-1:0] prog_last;
    logic [3:0]         reg_sel;
    logic               aw_got;
    logic               w_got;
    logic [7:0]         awaddr;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    lse_axi_rsp_t       rsp;
  } lse_st_t;

  lse_st_t            s;
  lse_st_t            next_s;
  logic [31:0]        prog [2**PROG_AW];
  logic               prog_we;
  lse_instr_t         ins;
  logic [63:0]        points;
  logic               pt;
  logic [3:0]         ri;
  logic [15:0]        acc;
  logic [15:0]        acc_new;
  logic [15:0]        preset;
  logic               tick;
  logic               term_ok;
  logic               term_clr;
  logic               done;
  logic [31:0]        wval;
  logic [31:0]        rval;
  logic [1:0]         rresp_v;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Current instruction and operand views
  assign ins    = lse_instr_t'(prog[s.pc]);
  assign points = {s.outs, s.inputs};
  assign ri     = ins.addr[3:0];
  assign acc    = s.regs[ri];
  assign preset = s.regs[4'(ri + 4'h1)];
  // Timebase 0, 1, 2 picks the 0.01 s, 0.1 s or 1 s tick
  assign tick   = s.scan_tick[ins.addr[9:8]];

  // Read decode
  always_comb begin
    rval    = RESET_WORD;
    rresp_v = RESP_OKAY;
    unique case (axi_req.araddr)
      OFS_CTRL:      rval[CTRL_RUN_BIT] = s.run;
      OFS_STATUS:    rval = {s.scan_count, 8'(s.pc), 4'h0, s.jumping,
                             s.skipping, s.st};
      OFS_PROG_ADDR: rval = 32'(s.prog_addr);
      OFS_PROG_DATA: rval = prog[s.prog_addr];
      OFS_PROG_LAST: rval = 32'(s.prog_last);
      OFS_INPUTS:    rval = s.inputs;
      OFS_OUTPUTS:   rval = s.outs;
      OFS_REG_SEL:   rval = 32'(s.reg_sel);
      OFS_REG_DATA:  rval = 32'(s.regs[s.reg_sel]);
      default:       rresp_v = RESP_SLVERR;
    endcase
  end

  // Next state: bus slave, tick dividers, then one instruction
  always_comb begin
    next_s   = s;
    prog_we  = 1'b0;
    wval     = RESET_WORD;
    pt       = 1'b0;
    acc_new  = acc;
    done     = 1'b0;
    term_ok  = !s.skipping;
    term_clr = s.skipping && s.skip_clear;

    // Write address and data taken in either order
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      next_s.aw_got    = 1'b0;
      next_s.w_got     = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = RESP_OKAY;
      unique case (s.awaddr)
        OFS_CTRL: begin
          wval       = merge(32'(s.run), s.wdata, s.wstrb);
          next_s.run = wval[CTRL_RUN_BIT];
        end
        OFS_PROG_ADDR: begin
          wval             = merge(32'(s.prog_addr), s.wdata, s.wstrb);
          next_s.prog_addr = wval[PROG_AW-1:0];
        end
        OFS_PROG_DATA: begin
          prog_we          = 1'b1;
          next_s.prog_addr = s.prog_addr + 1'b1;
        end
        OFS_PROG_LAST: begin
          wval             = merge(32'(s.prog_last), s.wdata, s.wstrb);
          next_s.prog_last = wval[PROG_AW-1:0];
        end
        OFS_INPUTS: next_s.inputs = merge(s.inputs, s.wdata, s.wstrb);
        OFS_REG_SEL: begin
          wval           = merge(32'(s.reg_sel), s.wdata, s.wstrb);
          next_s.reg_sel = wval[3:0];
        end
        OFS_REG_DATA: begin
          wval = merge(32'(s.regs[s.reg_sel]), s.wdata, s.wstrb);
          next_s.regs[s.reg_sel] = wval[15:0];
        end
        OFS_STATUS, OFS_OUTPUTS: ;
        default: next_s.rsp.bresp = RESP_SLVERR;
      endcase
    end
    next_s.rsp.awready = !next_s.aw_got;
    next_s.rsp.wready  = !next_s.w_got;

    // Read channel
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid  = 1'b1;
      next_s.rsp.rdata   = rval;
      next_s.rsp.rresp   = rresp_v;
    end else if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid  = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    // Tick chain, pending ticks are caught per scan
    next_s.tick_cnt = s.tick_cnt + 1'b1;
    if (s.tick_cnt == TW'(TICK_CNT - 1)) begin
      next_s.tick_cnt     = '0;
      next_s.tick_pend[0] = 1'b1;
      next_s.div1         = s.div1 + 4'h1;
      if (s.div1 == 4'(TICK_DIV - 1)) begin
        next_s.div1         = 4'h0;
        next_s.tick_pend[1] = 1'b1;
        next_s.div2         = s.div2 + 4'h1;
        if (s.div2 == 4'(TICK_DIV - 1)) begin
          next_s.div2         = 4'h0;
          next_s.tick_pend[2] = 1'b1;
        end
      end
    end

    unique case (s.st)
      ST_IDLE: begin
        if (s.run) begin
          next_s.st = ST_RUN;
          next_s.pc = '0;
        end
      end
      ST_DELAY: begin
        next_s.dly_sub = s.dly_sub + 1'b1;
        if (s.dly_sub == DSW'(DELAY_UNIT_CYCLES - 1)) begin
          next_s.dly_sub = '0;
          next_s.dly_cnt = s.dly_cnt - 16'h0001;
          if (s.dly_cnt == 16'h0001) begin
            next_s.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        next_s.pc = s.pc + 1'b1;
        if (s.jumping) begin
          if (ins.op == OP_END_JUMP && ins.addr == s.jump_addr) begin
            next_s.jumping = 1'b0;
            next_s.line    = 1'b1;
          end
        end else begin
          pt = ins.force_en ? ins.force_val : points[ins.addr[5:0]];
          unique case (ins.op)
            OP_CONTACT_NO: next_s.line = s.line & pt;
            OP_CONTACT_NC: next_s.line = s.line & !pt;
            OP_RISE: next_s.line = s.line & s.snap[ins.addr[5:0]] &
                                   !s.prev[ins.addr[5:0]];
            OP_FALL: next_s.line = s.line & !s.snap[ins.addr[5:0]] &
                                   s.prev[ins.addr[5:0]];
            OP_INVERT: next_s.line = !s.line;
            OP_BIT_READ: next_s.line = s.line & s.regs[ri][ins.aux[3:0]];
            OP_SAVE: begin
              next_s.hold = s.line;
              next_s.line = 1'b1;
            end
            OP_COIL, OP_LATCH, OP_UNLATCH: begin
              next_s.line = 1'b1;
              if (term_clr) begin
                next_s.outs[ins.addr[4:0]] = 1'b0;
              end else if (term_ok && ins.op == OP_COIL) begin
                next_s.outs[ins.addr[4:0]] = s.line;
              end else if (term_ok && ins.op == OP_LATCH && s.line) begin
                next_s.outs[ins.addr[4:0]] = 1'b1;
              end else if (term_ok && ins.op == OP_UNLATCH && s.line) begin
                next_s.outs[ins.addr[4:0]] = 1'b0;
              end
            end
            OP_BIT_WRITE: begin
              next_s.line = 1'b1;
              // Bit follows line, cleared in clear-skip
              if (term_ok || term_clr) begin
                next_s.regs[ri][ins.aux[3:0]] = s.line & !term_clr;
              end
            end
            OP_DELAY: begin
              next_s.line = 1'b1;
              // Only when true and not skipping
              if (s.line && !s.skipping && acc != 16'h0000) begin
                next_s.st      = ST_DELAY;
                next_s.dly_cnt = acc;
                next_s.dly_sub = '0;
              end
            end
            OP_TON, OP_TOF, OP_RTO, OP_COUNTER: begin
              next_s.line = 1'b1;
              unique case (ins.op)
                OP_TON: begin
                  // Count while true, clear when false
                  if (!s.line) begin
                    acc_new = 16'h0000;
                  end else if (tick && acc != preset) begin
                    acc_new = acc + 16'h0001;
                  end
                  done = s.line && acc_new == preset;
                end
                OP_TOF: begin
                  // Count while false, off at preset
                  if (s.line) begin
                    acc_new = 16'h0000;
                  end else if (tick && acc != preset) begin
                    acc_new = acc + 16'h0001;
                  end
                  done = s.line || acc_new != preset;
                end
                OP_RTO: begin
                  // Reset low clears, run low holds
                  if (!s.hold) begin
                    acc_new = 16'h0000;
                  end else if (s.line && tick && acc != preset) begin
                    acc_new = acc + 16'h0001;
                  end
                  done = acc_new == preset;
                end
                default: begin
                  // Step on count edge, reset low clears
                  if (!s.hold) begin
                    acc_new = 16'h0000;
                  end else if (s.line && !s.cnt_prev[ri]) begin
                    acc_new = ins.addr[CTR_DOWN_BIT] ? acc - 16'h0001
                                                     : acc + 16'h0001;
                  end
                  done = acc_new == preset;
                end
              endcase
              if (term_ok) begin
                next_s.cnt_prev[ri]      = s.line;
                next_s.regs[ri]          = acc_new;
                next_s.outs[ins.aux]     = done;
              end else if (term_clr) begin
                next_s.outs[ins.aux]     = 1'b0;
              end
            end
            OP_SKIP_HOLD, OP_SKIP_CLEAR: begin
              next_s.line = 1'b1;
              // Open a skip region on false
              if (!s.line && !s.skipping) begin
                next_s.skipping   = 1'b1;
                next_s.skip_clear = ins.op == OP_SKIP_CLEAR;
                next_s.skip_addr  = ins.addr;
              end
            end
            OP_END_SKIP: begin
              next_s.line = 1'b1;
              if (ins.addr == s.skip_addr) begin
                next_s.skipping = 1'b0;
              end
            end
            OP_JUMP: begin
              next_s.line = 1'b1;
              if (!s.line) begin
                next_s.jumping   = 1'b1;
                next_s.jump_addr = ins.addr;
              end
            end
            OP_END_JUMP, OP_NOP, OP_RETURN: next_s.line = 1'b1;
            default: next_s.line = 1'b1;
          endcase
        end
        // Return outside a jump region or last word restarts the scan
        if ((ins.op == OP_RETURN && !s.jumping) || s.pc == s.prog_last) begin
          next_s.pc = '0;
          // New scan starts with a true line
          next_s.line       = 1'b1;
          next_s.skipping   = 1'b0;
          next_s.jumping    = 1'b0;
          next_s.prev       = s.snap;
          next_s.snap       = {next_s.outs, next_s.inputs};
          next_s.scan_tick  = s.tick_pend;
          next_s.tick_pend  = next_s.tick_pend & ~s.tick_pend;
          next_s.scan_count = s.scan_count + 16'h0001;
        end
        if (!s.run) begin
          next_s.st = ST_IDLE;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Synchronous reset, retentive outputs keep their state
    if (!aresetn) begin
      next_s             = '0;
      next_s.st          = ST_IDLE;
      next_s.line        = 1'b1;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready  = 1'b1;
      next_s.rsp.arready = 1'b1;
      next_s.outs        = s.outs & RETAIN_MASK;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    s <= next_s;
  end

  // Program memory write port
  always_ff @(posedge aclk) begin
    if (prog_we && aresetn) begin
      prog[s.prog_addr] <= merge(prog[s.prog_addr], s.wdata, s.wstrb);
    end
  end

  // Outputs straight from state flops
  assign axi_rsp     = s.rsp;
  assign coil_out    = s.outs;
  // Bit 0 of the state is set in run and delay only
  assign scan_active = s.st[0];
endmodule // lse_executor

`default_nettype wire

// ==== design/lse_pkg.sv ====
/*
  Shared constants and types of the ladder scan executor: register map,
  instruction word layout, opcodes, timing counts and bus carriers.
  Assumes a 50 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package lse_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_PROG_ADDR = 8'h08;
  localparam logic [7:0] OFS_PROG_DATA = 8'h0C;
  localparam logic [7:0] OFS_PROG_LAST = 8'h10;
  localparam logic [7:0] OFS_INPUTS    = 8'h14;
  localparam logic [7:0] OFS_OUTPUTS   = 8'h18;
  localparam logic [7:0] OFS_REG_SEL   = 8'h1C;
  localparam logic [7:0] OFS_REG_DATA  = 8'h20;
  // Field positions and reset values
  localparam int         CTRL_RUN_BIT  = 0;
  localparam int         POINT_OUT_BIT = 5;
  localparam int         CTR_DOWN_BIT  = 9;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;
  // Timing
  localparam int CLK_PERIOD_NS     = 20;
  localparam int TICK_PERIOD_NS    = 10_000_000;
  localparam int TICK_CYCLES       = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_DIV          = 10;
  localparam int DELAY_UNIT_NS     = 1000;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    OP_NOP      = 5'h00, OP_CONTACT_NO = 5'h01, OP_CONTACT_NC = 5'h02,
    OP_RISE     = 5'h03, OP_FALL       = 5'h04, OP_COIL       = 5'h05,
    OP_LATCH    = 5'h06, OP_UNLATCH    = 5'h07, OP_INVERT     = 5'h08,
    OP_BIT_READ = 5'h09, OP_BIT_WRITE  = 5'h0A, OP_DELAY      = 5'h0B,
    OP_TON      = 5'h0C, OP_TOF        = 5'h0D, OP_RTO        = 5'h0E,
    OP_COUNTER  = 5'h0F, OP_SKIP_HOLD  = 5'h10, OP_SKIP_CLEAR = 5'h11,
    OP_END_SKIP = 5'h12, OP_JUMP       = 5'h13, OP_END_JUMP   = 5'h14,
    OP_RETURN   = 5'h15, OP_SAVE       = 5'h16
  } lse_op_t;

  typedef struct packed {
    logic [9:0] pad;
    logic       force_val;   // Bit 21
    logic       force_en;    // Bit 20
    lse_op_t    op;          // Bits 19:15
    logic [4:0] aux;         // Bit select or coil point
    logic [9:0] addr;        // Point, register or region address
  } lse_instr_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_DELAY = 2'b11
  } lse_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } lse_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lse_axi_rsp_t;
endpackage

// ==== tb/ladder_scan_executor_tb_top.sv ====
/*
  Self-checking bench of the scan executor: bus, contacts, coils,
  latches, bits, one-shots, counter, timer, skip and jump.
  Assumes the executor's AXI4-Lite map and a short timer tick.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); \
  end \
end
module ladder_scan_executor_tb_top;
  import lse_pkg::*;
  logic         aclk;
  logic         aresetn;
  lse_axi_req_t req;
  lse_axi_rsp_t rsp;
  logic [31:0]  coil_out;
  logic         scan_active;
  logic [1:0]   resp;
  logic [31:0]  rdv;
  logic [31:0]  pg[$];
  int           n_mismatch;
  int           cmp_count;

  // Executor with a ten-cycle tick
  lse_executor #(.TICK_CNT(10)) u_dut (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .axi_req     (req),
    .axi_rsp     (rsp),
    .coil_out    (coil_out),
    .scan_active (scan_active)
  );

  // Clock
  always #10 aclk = ~aclk;

  // Instruction word
  function automatic logic [31:0] ins(lse_op_t o, int a, int x = 0);
    return {12'h000, o, 5'(x), 10'(a)};
  endfunction

  // Write with address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
    end while (req.awvalid && !rsp.awready || req.wvalid && !rsp.wready);
    do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // Read, accepting the data one cycle late
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    @(posedge aclk);
    req.rready <= 1'b1;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    rdv = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // Reset, load pg and start scanning
  task automatic load;
    rst();
    wr(OFS_PROG_ADDR, 32'h0000_0000);
    foreach (pg[i]) wr(OFS_PROG_DATA, pg[i]);
    wr(OFS_PROG_LAST, 32'(pg.size() - 1));
    wr(OFS_CTRL, 32'h0000_0001);
  endtask

  // Set inputs, let several scans pass, compare coils
  task automatic step(input logic [31:0] i, input logic [31:0] e);
    wr(OFS_INPUTS, i);
    repeat (100) @(posedge aclk);
    `CHK(coil_out, e)
  endtask

  task automatic regr(input logic [31:0] s);
    wr(OFS_REG_SEL, s);
    rd(OFS_REG_DATA);
  endtask

  task automatic t_bus;
    rst();
    `CHK(scan_active, 1'b0)
    rd(OFS_CTRL);
    `CHK(rdv, RESET_WORD)
    rd(8'h40);
    `CHK(resp, RESP_SLVERR)
    wr(8'h40, 32'hFFFF_FFFF);
    `CHK(resp, RESP_SLVERR)
    wr(OFS_OUTPUTS, 32'hFFFF_FFFF);
    rd(OFS_OUTPUTS);
    `CHK(rdv, RESET_WORD)
    $display("bus done");
  endtask

  task automatic t_contact;
    pg = {ins(OP_CONTACT_NO, 0), ins(OP_COIL, 0), ins(OP_CONTACT_NC, 1),
          ins(OP_COIL, 1), ins(OP_CONTACT_NO, 2) | 32'h0030_0000,
          ins(OP_COIL, 2), ins(OP_CONTACT_NO, 0), ins(OP_INVERT, 0),
          ins(OP_COIL, 3), ins(OP_CONTACT_NO, 32), ins(OP_COIL, 4),
          ins(OP_RETURN, 0), ins(OP_COIL, 5)};
    load();
    step(32'h0000_0001, 32'h0000_0017);
    step(32'h0000_0002, 32'h0000_000C);
    $display("contact done");
  endtask

  task automatic t_latch;
    pg = {ins(OP_CONTACT_NO, 0), ins(OP_LATCH, 0), ins(OP_CONTACT_NO, 1),
          ins(OP_UNLATCH, 0)};
    load();
    step(32'h0000_0001, 32'h0000_0001);
    step(32'h0000_0000, 32'h0000_0001);
    step(32'h0000_0002, 32'h0000_0000);
    step(32'h0000_0000, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0000);
    step(32'h0000_0001, 32'h0000_0000);
    `CHK(scan_active, 1'b0)
    $display("latch done");
  endtask

  task automatic t_bits;
    pg = {ins(OP_CONTACT_NO, 0), ins(OP_BIT_WRITE, 3, 5),
          ins(OP_BIT_READ, 3, 5), ins(OP_COIL, 0)};
    load();
    step(32'h0000_0001, 32'h0000_0001);
    regr(32'h0000_0003);
    `CHK(rdv, 32'h0000_0020)
    step(32'h0000_0000, 32'h0000_0000);
    regr(32'h0000_0003);
    `CHK(rdv, 32'h0000_0000)
    $display("bits done");
  endtask

  task automatic t_shot;
    pg = {ins(OP_RISE, 0), ins(OP_COIL, 0), ins(OP_CONTACT_NO, 32),
          ins(OP_LATCH, 1), ins(OP_FALL, 0), ins(OP_COIL, 2),
          ins(OP_CONTACT_NO, 34), ins(OP_LATCH, 3)};
    load();
    step(32'h0000_0000, 32'h0000_0000);
    step(32'h0000_0001, 32'h0000_0002);
    step(32'h0000_0000, 32'h0000_000A);
    $display("one-shot done");
  endtask

  task automatic t_count;
    pg = {ins(OP_CONTACT_NO, 1), ins(OP_SAVE, 0), ins(OP_CONTACT_NO, 0),
          ins(OP_COUNTER, 0, 0), ins(OP_CONTACT_NO, 2), ins(OP_TON, 2, 1)};
    load();
    wr(OFS_REG_SEL, 32'h0000_0001);
    wr(OFS_REG_DATA, 32'h0000_0002);
    wr(OFS_REG_SEL, 32'h0000_0003);
    wr(OFS_REG_DATA, 32'h0000_0003);
    step(32'h0000_0002, 32'h0000_0000);
    step(32'h0000_0003, 32'h0000_0000);
    step(32'h0000_0002, 32'h0000_0000);
    step(32'h0000_0003, 32'h0000_0001);
    regr(32'h0000_0000);
    `CHK(rdv, 32'h0000_0002)
    step(32'h0000_0006, 32'h0000_0003);
    step(32'h0000_0002, 32'h0000_0001);
    regr(32'h0000_0002);
    `CHK(rdv, 32'h0000_0000)
    wr(OFS_INPUTS, 32'h0000_0000);
    repeat (100) @(posedge aclk);
    regr(32'h0000_0000);
    `CHK(rdv, 32'h0000_0000)
    $display("count done");
  endtask

  task automatic regw(input logic [31:0] s, input logic [31:0] d);
    wr(OFS_REG_SEL, s);
    wr(OFS_REG_DATA, d);
  endtask

  task automatic t_timer;
    pg = {ins(OP_CONTACT_NO, 1), ins(OP_SAVE, 0), ins(OP_CONTACT_NO, 0),
          ins(OP_RTO, 0, 0), ins(OP_CONTACT_NO, 2), ins(OP_TOF, 2, 1),
          ins(OP_CONTACT_NO, 3), ins(OP_DELAY, 4)};
    load();
    regw(32'h0000_0001, 32'h0000_0003);
    regw(32'h0000_0003, 32'h0000_0003);
    regw(32'h0000_0004, 32'h0000_0014);
    step(32'h0000_0006, 32'h0000_0002);
    step(32'h0000_0007, 32'h0000_0003);
    step(32'h0000_0002, 32'h0000_0001);
    regr(32'h0000_0000);
    `CHK(rdv, 32'h0000_0003)
    step(32'h0000_0000, 32'h0000_0000);
    rd(OFS_STATUS);
    `CHK(rdv[1:0], 2'b01)
    wr(OFS_INPUTS, 32'h0000_0008);
    repeat (100) @(posedge aclk);
    rd(OFS_STATUS);
    `CHK(rdv[1:0], 2'b11)
    `CHK(scan_active, 1'b1)
    $display("timer done");
  endtask

  task automatic t_skip;
    pg = {ins(OP_CONTACT_NO, 1), ins(OP_SKIP_CLEAR, 5), ins(OP_END_SKIP, 9),
          ins(OP_CONTACT_NO, 0), ins(OP_COIL, 0), ins(OP_END_SKIP, 5),
          ins(OP_CONTACT_NO, 2), ins(OP_SKIP_HOLD, 6), ins(OP_CONTACT_NO, 0),
          ins(OP_COIL, 1), ins(OP_END_SKIP, 6), ins(OP_CONTACT_NO, 3),
          ins(OP_JUMP, 7), ins(OP_CONTACT_NO, 0), ins(OP_COIL, 2),
          ins(OP_END_JUMP, 7), ins(OP_CONTACT_NO, 0), ins(OP_COIL, 3)};
    load();
    step(32'h0000_000F, 32'h0000_000F);
    step(32'h0000_0001, 32'h0000_000E);
    step(32'h0000_0000, 32'h0000_0006);
    $display("skip done");
  endtask

  // Verdict
  task automatic summarize;
    $display("Checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(20 * 40_000);
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    n_mismatch = 0;
    cmp_count = 0;
    t_bus();
    t_contact();
    t_latch();
    t_bits();
    t_shot();
    t_count();
    t_timer();
    t_skip();
    summarize();
  end
endmodule // ladder_scan_executor_tb_top

// Checker on the executor's ports
bind lse_executor lse_exec_sva #(.RETAIN_MASK(RETAIN_MASK)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .coil_out(coil_out), .scan_active(scan_active));
`default_nettype wire

// ==== tb/lse_exec_sva.sv ====
/*
  Checker of the executor's bus handshakes and coil table.
  Assumes a bind to the executor top with its RETAIN_MASK.
*/
`timescale 1ns/10ps
`default_nettype none
module lse_exec_sva #(
  parameter logic [31:0] RETAIN_MASK = 32'h0000_0000
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire lse_pkg::lse_axi_req_t axi_req,
  input wire lse_pkg::lse_axi_rsp_t axi_rsp,
  input wire logic [31:0]           coil_out,
  input wire logic                  scan_active
);
  import lse_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data taken together, read address taken
  sequence wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence ar_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence

  // Bus idle and plain coils clear on leaving reset, coils still while idle
  bus_idle_a: assert property ($rose(aresetn) |->
    axi_rsp.arready && !axi_rsp.bvalid && !axi_rsp.rvalid)
    else $error("Bus busy after reset");
  coil_retain_a: assert property ($rose(aresetn) |->
    (coil_out & ~RETAIN_MASK) == RESET_WORD)
    else $error("Plain coil kept over reset");
  idle_coil_a: assert property (!scan_active |=> $stable(coil_out))
    else $error("Coil changed while idle");
  // Write answered in two edges
  write_answer_a: assert property (wr_take |-> ##[1:2] axi_rsp.bvalid)
    else $error("Write not answered");
  write_busy_a: assert property (wr_take |=>
    !axi_rsp.awready && !axi_rsp.wready)
    else $error("Write channels ready during write");
  resp_taken_a: assert property (axi_rsp.bvalid && axi_req.bready |=>
    !axi_rsp.bvalid)
    else $error("Write response not retired");
  // Read answered next cycle and held
  read_answer_a: assert property (ar_take |=>
    axi_rsp.rvalid && !axi_rsp.arready)
    else $error("Read not answered");
  rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("Read data dropped");
  read_busy_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("Read address ready during read");
endmodule // lse_exec_sva
`default_nettype wire
